// file: hdl/pic_pkg.sv
// register map, field positions, vectors and carriers of the interrupt
// controller; assumes a 32-bit APB slave with word-spaced register indices
package pic_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [15:0] PIC_IDX_WAKE_EDGE = 16'hFF90;
  localparam logic [15:0] PIC_IDX_PIN_EDGE = 16'hFFF2;
  localparam logic [15:0] PIC_IDX_EN_ONE = 16'hFFF3;
  localparam logic [15:0] PIC_IDX_EN_TWO = 16'hFFF4;
  localparam logic [15:0] PIC_IDX_FLAG_ONE = 16'hFFF6;
  localparam logic [15:0] PIC_IDX_FLAG_TWO = 16'hFFF7;
  localparam logic [15:0] PIC_IDX_WAKE_FLAG = 16'hFFF9;
  localparam logic [15:0] PIC_IDX_GMASK = 16'hFF80;
  localparam logic [15:0] PIC_IDX_IRQ_STAT = 16'hFF81;
  localparam logic [15:0] PIC_IDX_IRQ_MASK = 16'hFF82;
  localparam logic [15:0] PIC_IDX_VECTOR = 16'hFF83;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] PIC_RST_WAKE_EDGE = 8'h00;
  localparam logic [7:0] PIC_RST_PIN_EDGE = 8'hE0;
  localparam logic [7:0] PIC_RST_EN = 8'h00;
  localparam logic [7:0] PIC_RST_FLAG_ONE = 8'h20;
  localparam logic [7:0] PIC_RST_FLAG_TWO = 8'h00;
  localparam logic [7:0] PIC_RST_WAKE_FLAG = 8'h00;
  localparam logic [2:0] PIC_PIN_EDGE_FIXED = 3'h7;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PIC_F1_TIMER_A = 7;
  localparam int PIC_F1_SYNC = 6;
  localparam int PIC_F1_WAKE = 5;
  localparam int PIC_F2_DT = 7;
  localparam int PIC_F2_AD = 6;
  localparam int PIC_F2_RSVD = 5;
  localparam int PIC_F2_TG = 4;
  localparam int PIC_F2_TFH = 3;
  localparam int PIC_F2_TFL = 2;
  localparam int PIC_F2_TC = 1;
  localparam int PIC_F2_EC = 0;
  localparam int PIC_ST_FLAG = 0;
  localparam int PIC_ST_ACCEPT = 1;
  localparam int PIC_ST_WAKE = 2;
  localparam int PIC_ST_W = 3;

  // ****************************************************************
  // vector numbers
  // ****************************************************************
  localparam logic [4:0] PIC_VEC_RSVD_LAST = 5'h03;
  localparam logic [4:0] PIC_VEC_PIN0 = 5'h04;
  localparam logic [4:0] PIC_VEC_WAKE = 5'h09;
  localparam logic [4:0] PIC_VEC_FIRST = 5'h04;
  localparam logic [4:0] PIC_VEC_LAST = 5'h14;
  localparam int PIC_VEC_N = 21;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic [4:0] number;
    logic [15:0] address;
  } pic_vec_type;

  typedef struct packed {
    logic sync_done;
    logic timer_a_ovf;
    logic event_cnt_ovf;
    logic timer_c;
    logic fl_cmp;
    logic fl_ovf;
    logic fh_cmp;
    logic fh_ovf;
    logic tg_cap;
    logic tg_ovf;
    logic ad_end;
    logic direct_xfer;
  } pic_evt_type;

endpackage

// file: hdl/pic_ctrl.sv
// prioritised interrupt controller with APB register access
// assumes pins are asynchronous, peripheral events are one-cycle pulses on
// clk, serial unit causes are levels held by their units
`timescale 1ns/1ps

// Functional notes
// - accept 13 pin requests and 24 internal peripheral causes
// - only the highest priority pending request is handed out, vector order
// - global mask set: flags still set but nothing is accepted
// - every interrupt and wakeup pin selects rising or falling edge
// - interrupt pins 0..4 use vectors 4..8; all wakeup pins share 9
// - serial unit one vector 17, unit two 18, converter 19, transfer 20
// - timer f upper compare and overflow both use vector 15
// - timer g capture and overflow both use vector 16
// - vector numbers pointing at bytes 2..7 are never issued
// - flag registers ignore written ones; writing zero clears
// - upper three pin edge bits read one and ignore writes
// - pin edge bit 4 also selects converter trigger edge, 0 falling
// - pin edge bits 4..0 select edge of the same pin index
// - reset sets the global mask bit to one
// - a pin request is handed out as a vector only while enabled; status bits and irq ignore the enable
module pic_ctrl #(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins
  input wire logic [4:0] irq_pin,
  input wire logic [7:0] wakeup_pin,
  input wire logic converter_trigger_pin,
  // on-chip peripherals
  input wire pic_pkg::pic_evt_type periph_evt,
  input wire logic [5:0] async_serial_unit_one,
  input wire logic [5:0] async_serial_unit_two,
  output logic converter_trigger_evt,
  // cpu core
  input wire logic cpu_ack,
  output pic_pkg::pic_vec_type cpu_vec,
  output logic cpu_imask,
  output logic irq
);
  import pic_pkg::*;

  localparam int NPIN = 14;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  wire [15:0] idx = paddr[17:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready_ff & pwrite & pstrb[0] & ~pslverr_ff;
  wire [7:0] wd = pwdata[7:0];
  wire hit_wedge = aligned & (idx == PIC_IDX_WAKE_EDGE);
  wire hit_pedge = aligned & (idx == PIC_IDX_PIN_EDGE);
  wire hit_en1 = aligned & (idx == PIC_IDX_EN_ONE);
  wire hit_en2 = aligned & (idx == PIC_IDX_EN_TWO);
  wire hit_f1 = aligned & (idx == PIC_IDX_FLAG_ONE);
  wire hit_f2 = aligned & (idx == PIC_IDX_FLAG_TWO);
  wire hit_wf = aligned & (idx == PIC_IDX_WAKE_FLAG);
  wire hit_gm = aligned & (idx == PIC_IDX_GMASK);
  wire hit_st = aligned & (idx == PIC_IDX_IRQ_STAT);
  wire hit_mk = aligned & (idx == PIC_IDX_IRQ_MASK);
  wire hit_vc = aligned & (idx == PIC_IDX_VECTOR);
  wire hit_any = hit_wedge | hit_pedge | hit_en1 | hit_en2 | hit_f1 |
                 hit_f2 | hit_wf | hit_gm | hit_st | hit_mk | hit_vc;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] wedge_ff;
  logic [4:0] pedge_ff;
  logic [7:0] en1_ff;
  logic [7:0] en2_ff;
  logic [7:0] f1_ff;
  logic [7:0] f2_ff;
  logic [7:0] wf_ff;
  logic imask_ff;
  logic [PIC_ST_W-1:0] stat_ff;
  logic [PIC_ST_W-1:0] mask_ff;
  logic irq_ff;
  logic conv_evt_ff;
  pic_vec_type vec_ff;
  logic [PIC_VEC_N-1:0] pend_q_ff;

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic [NPIN-1:0] s1_ff;
  logic [NPIN-1:0] s2_ff;
  logic [NPIN-1:0] s3_ff;
  logic [NPIN-1:0] lvl_ff;
  logic [NPIN-1:0] det;
  wire [NPIN-1:0] raw = {converter_trigger_pin, wakeup_pin, irq_pin};
  wire [NPIN-1:0] esel = {pedge_ff[4], wedge_ff, pedge_ff};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      wire stable = (s2_ff[gi] == s3_ff[gi]);
      // a new stable level matching the selected edge polarity
      assign det[gi] = stable & (s3_ff[gi] != lvl_ff[gi]) &
                       (s3_ff[gi] == esel[gi]);
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          s1_ff[gi] <= 1'b1;
          s2_ff[gi] <= 1'b1;
          s3_ff[gi] <= 1'b1;
          lvl_ff[gi] <= 1'b1;
        end else begin
          s1_ff[gi] <= raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (stable) begin
            lvl_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // flag set and clear
  // ****************************************************************
  wire [7:0] set1 = {periph_evt.timer_a_ovf, periph_evt.sync_done,
                     1'b0, det[4:0]};
  wire [7:0] set2 = {periph_evt.direct_xfer, periph_evt.ad_end, 1'b0,
                     periph_evt.tg_cap | periph_evt.tg_ovf,
                     periph_evt.fh_cmp | periph_evt.fh_ovf,
                     periph_evt.fl_cmp | periph_evt.fl_ovf,
                     periph_evt.timer_c, periph_evt.event_cnt_ovf};
  wire [7:0] setw = det[12:5];
  // written ones keep the flag, zeros clear it, a new event wins
  wire [7:0] nxt_f1 = ((hit_f1 & wr) ? (f1_ff & wd) : f1_ff) | set1 |
                      PIC_RST_FLAG_ONE;
  wire [7:0] nxt_f2 = (((hit_f2 & wr) ? (f2_ff & wd) : f2_ff) | set2) &
                      ~(8'h01 << PIC_F2_RSVD);
  wire [7:0] nxt_wf = ((hit_wf & wr) ? (wf_ff & wd) : wf_ff) | setw;

  // ****************************************************************
  // pending vectors and priority
  // ****************************************************************
  logic [PIC_VEC_N-1:0] pend;
  assign pend[3:0] = 4'h0;
  assign pend[8:4] = f1_ff[4:0] & en1_ff[4:0];
  assign pend[9] = (|wf_ff) & en1_ff[PIC_F1_WAKE];
  assign pend[10] = f1_ff[PIC_F1_SYNC] & en1_ff[PIC_F1_SYNC];
  assign pend[11] = f1_ff[PIC_F1_TIMER_A] & en1_ff[PIC_F1_TIMER_A];
  assign pend[12] = f2_ff[PIC_F2_EC] & en2_ff[PIC_F2_EC];
  assign pend[13] = f2_ff[PIC_F2_TC] & en2_ff[PIC_F2_TC];
  assign pend[14] = f2_ff[PIC_F2_TFL] & en2_ff[PIC_F2_TFL];
  assign pend[15] = f2_ff[PIC_F2_TFH] & en2_ff[PIC_F2_TFH];
  assign pend[16] = f2_ff[PIC_F2_TG] & en2_ff[PIC_F2_TG];
  assign pend[17] = |async_serial_unit_one;
  assign pend[18] = |async_serial_unit_two;
  assign pend[19] = f2_ff[PIC_F2_AD] & en2_ff[PIC_F2_AD];
  assign pend[20] = f2_ff[PIC_F2_DT] & en2_ff[PIC_F2_DT];

  function automatic logic [4:0] pic_first(input logic [PIC_VEC_N-1:0] p);
    logic [4:0] n;
    n = PIC_VEC_FIRST;
    for (int i = PIC_VEC_N - 1; i >= int'(PIC_VEC_FIRST); i--) begin
      if (p[i]) begin
        n = 5'(i);
      end
    end
    return n;
  endfunction

  pic_vec_type nxt_vec;
  wire [4:0] win = pic_first(pend);
  assign nxt_vec.valid = (|pend) & ~imask_ff & ~cpu_ack;
  assign nxt_vec.number = win;
  assign nxt_vec.address = {10'h000, win, 1'b0};

  // ****************************************************************
  // global mask, status and interrupt line
  // ****************************************************************
  wire nxt_imask = cpu_ack | ((hit_gm & wr) ? wd[0] : imask_ff);
  wire [PIC_ST_W-1:0] ev = {|setw, cpu_ack, |{set1, set2, setw}};
  wire [PIC_ST_W-1:0] nxt_stat =
    ((hit_st & wr) ? (stat_ff & ~wd[PIC_ST_W-1:0]) : stat_ff) | ev;
  wire [PIC_ST_W-1:0] nxt_mask = (hit_mk & wr) ? wd[PIC_ST_W-1:0] : mask_ff;

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_wedge) nxt_prdata[7:0] = wedge_ff;
    if (hit_pedge) nxt_prdata[7:0] = {PIC_PIN_EDGE_FIXED, pedge_ff};
    if (hit_en1) nxt_prdata[7:0] = en1_ff;
    if (hit_en2) nxt_prdata[7:0] = en2_ff;
    if (hit_f1) nxt_prdata[7:0] = f1_ff;
    if (hit_f2) nxt_prdata[7:0] = f2_ff;
    if (hit_wf) nxt_prdata[7:0] = wf_ff;
    if (hit_gm) nxt_prdata[0] = imask_ff;
    if (hit_st) nxt_prdata[PIC_ST_W-1:0] = stat_ff;
    if (hit_mk) nxt_prdata[PIC_ST_W-1:0] = mask_ff;
    if (hit_vc) nxt_prdata[21:0] = {vec_ff.valid, vec_ff.number,
                                    vec_ff.address};
  end

  // ****************************************************************
  // apb response
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit_any;
      if (setup) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wedge_ff <= PIC_RST_WAKE_EDGE;
      pedge_ff <= PIC_RST_PIN_EDGE[4:0];
      en1_ff <= PIC_RST_EN;
      en2_ff <= PIC_RST_EN;
    end else begin
      if (hit_wedge & wr) wedge_ff <= wd;
      if (hit_pedge & wr) pedge_ff <= wd[4:0];
      if (hit_en1 & wr) en1_ff <= wd;
      if (hit_en2 & wr) en2_ff <= wd;
    end
  end

  // ****************************************************************
  // flags, mask bit, vector and interrupt state
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      f1_ff <= PIC_RST_FLAG_ONE;
      f2_ff <= PIC_RST_FLAG_TWO;
      wf_ff <= PIC_RST_WAKE_FLAG;
      imask_ff <= 1'b1;
      stat_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
      conv_evt_ff <= 1'b0;
      vec_ff <= '0;
      pend_q_ff <= '0;
    end else begin
      f1_ff <= nxt_f1;
      f2_ff <= nxt_f2;
      wf_ff <= nxt_wf;
      imask_ff <= nxt_imask;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      irq_ff <= |(nxt_stat & nxt_mask);
      conv_evt_ff <= det[13];
      vec_ff <= nxt_vec;
      pend_q_ff <= pend;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cpu_vec = vec_ff;
  assign cpu_imask = imask_ff;
  assign irq = irq_ff;
  assign converter_trigger_evt = conv_evt_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_vec_not_reserved: assert property (
    @(posedge clk) disable iff (!rst_b)
    vec_ff.valid |-> (vec_ff.number > PIC_VEC_RSVD_LAST) &&
                     (vec_ff.number <= PIC_VEC_LAST))
    else $error("vector number in reserved range");

  a_vec_addr_double: assert property (
    @(posedge clk) disable iff (!rst_b)
    vec_ff.valid |-> vec_ff.address == {10'h000, vec_ff.number, 1'b0})
    else $error("vector address not twice the number");

  a_mask_blocks_accept: assert property (
    @(posedge clk) disable iff (!rst_b)
    imask_ff |=> !vec_ff.valid)
    else $error("request issued while globally masked");

  a_reset_sets_mask: assert property (
    @(posedge clk) !rst_b |=> imask_ff)
    else $error("mask bit not set by reset");

  a_prio_highest_win: assert property (
    @(posedge clk) disable iff (!rst_b)
    vec_ff.valid |-> pend_q_ff[vec_ff.number] &&
      ((pend_q_ff & (21'((21'h1 << vec_ff.number) - 21'h1))) == 21'h0))
    else $error("issued vector not the highest pending");

  a_pin_flag_sets: assert property (
    @(posedge clk) disable iff (!rst_b)
    det[0] |=> f1_ff[0] && $stable(det[0]) || f1_ff[0])
    else $error("pin flag not set after edge");

  a_write_one_keeps: assert property (
    @(posedge clk) disable iff (!rst_b)
    (hit_wf & wr & (wd == 8'hFF)) |=> (wf_ff & $past(wf_ff)) ==
                                        $past(wf_ff))
    else $error("writing one cleared a wakeup flag");

  a_edge_upper_ones: assert property (
    @(posedge clk) disable iff (!rst_b)
    (setup & hit_pedge) |=> prdata_ff[7:5] == PIC_PIN_EDGE_FIXED)
    else $error("pin edge upper bits not read as one");

  a_wake_shared_vec: assert property (
    @(posedge clk) disable iff (!rst_b)
    (vec_ff.valid && vec_ff.number == PIC_VEC_WAKE) |->
      $past(|wf_ff) && $past(en1_ff[PIC_F1_WAKE]))
    else $error("wakeup vector without a wakeup request");

  a_disabled_pin_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    !en1_ff[0] |=> !(vec_ff.valid && vec_ff.number == PIC_VEC_PIN0))
    else $error("disabled pin request issued");

  a_trigger_polarity: assert property (
    @(posedge clk) disable iff (!rst_b)
    conv_evt_ff |-> $past(s3_ff[13] == pedge_ff[4]))
    else $error("converter trigger on unselected edge");

  a_pin_edge_match: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(f1_ff[0]) |-> $past(s3_ff[0] == pedge_ff[0]))
    else $error("pin flag set on unselected edge");

  a_wake_edge_match: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(wf_ff[0]) |-> $past(s3_ff[5] == wedge_ff[0]))
    else $error("wakeup flag set on unselected edge");

  a_flag_write_ones: assert property (
    @(posedge clk) disable iff (!rst_b)
    (hit_f1 & wr & (wd == 8'hFF)) |=> (f1_ff & $past(f1_ff)) ==
                                        $past(f1_ff))
    else $error("writing one cleared a request flag");

  a_flag_clear_only: assert property (
    @(posedge clk) disable iff (!rst_b)
    $fell(f1_ff[0]) |-> $past(hit_f1 & wr & ~wd[0]))
    else $error("pin flag dropped without a clearing write");

endmodule // pic_ctrl

// file: verification/pic_cpu_model.sv
// cpu core model: takes the vector handed out by the interrupt controller
// assumes cpu_vec is a registered level on clk and cpu_ack a one-cycle pulse
`timescale 1ns/1ps

module pic_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // controller side
  input wire pic_pkg::pic_vec_type cpu_vec,
  output logic cpu_ack,
  // bench control
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  output logic [4:0] taken_ff
);
  import pic_pkg::*;
  logic [3:0] wait_ff;

  // ****************************************************************
  // accept a standing vector after ack_dly cycles
  // ****************************************************************
  always_ff @(posedge clk) begin
    cpu_ack <= 1'b0;
    if (!rst_b) begin
      wait_ff <= 4'h0;
      taken_ff <= 5'h00;
    end else if (cpu_vec.valid && ack_en && !cpu_ack) begin
      if (wait_ff == ack_dly) begin
        cpu_ack <= 1'b1;
        taken_ff <= cpu_vec.number;
        wait_ff <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end else begin
      wait_ff <= 4'h0;
    end
  end
endmodule // pic_cpu_model

// file: verification/prioritized_interrupt_controller_tb.sv
// self-checking bench of the interrupt controller
// assumes pic_ctrl with an apb slave and the cpu core model beside it
`timescale 1ns/1ps

module prioritized_interrupt_controller_tb;
  import pic_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] irq_pin = 5'h1F;
  logic [7:0] wakeup_pin = 8'hFF;
  logic conv_pin = 1'b1;
  pic_evt_type periph_evt = '0;
  logic [5:0] ser_one = 6'h00;
  logic [5:0] ser_two = 6'h00;
  logic conv_evt;
  logic cpu_ack;
  pic_vec_type cpu_vec;
  logic cpu_imask;
  logic irq;
  logic ack_en = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [4:0] taken;
  int bad_count = 0;
  int num_checks = 0;
  int conv_cnt = 0;
  int i;
  logic [31:0] d;
  logic e;
  logic [15:0] ridx [8] = '{PIC_IDX_WAKE_EDGE, PIC_IDX_PIN_EDGE,
    PIC_IDX_EN_ONE, PIC_IDX_EN_TWO, PIC_IDX_FLAG_ONE, PIC_IDX_FLAG_TWO,
    PIC_IDX_WAKE_FLAG, PIC_IDX_GMASK};
  logic [7:0] rval [8] = '{8'h00, 8'hE0, 8'h00, 8'h00, 8'h20, 8'h00,
    8'h00, 8'h01};
  logic [4:0] pvec [12] = '{5'h14, 5'h13, 5'h10, 5'h10, 5'h0F, 5'h0F,
    5'h0E, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A};

  // ****************************************************************
  // design and cpu model
  // ****************************************************************
  pic_ctrl #(.ADDR_W(18)) u_pic_ctrl (.clk(clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_pin(irq_pin), .wakeup_pin(wakeup_pin),
    .converter_trigger_pin(conv_pin), .periph_evt(periph_evt),
    .async_serial_unit_one(ser_one), .async_serial_unit_two(ser_two),
    .converter_trigger_evt(conv_evt), .cpu_ack(cpu_ack),
    .cpu_vec(cpu_vec), .cpu_imask(cpu_imask), .irq(irq));
  pic_cpu_model u_pic_cpu_model (.clk(clk), .rst_b(rst_b),
    .cpu_vec(cpu_vec), .cpu_ack(cpu_ack), .ack_en(ack_en),
    .ack_dly(ack_dly), .taken_ff(taken));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (conv_evt === 1'b1) begin
      conv_cnt++;
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx,
    input logic [7:0] wd, output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdat = prdata;
    err = pslverr;
    chk(n < 40, 1'b1, "pready wait");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] x;
    logic r;
    apb(1'b1, idx, wd, x, r);
    chk(r, 1'b0, "slave error");
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] x);
    logic r;
    apb(1'b0, idx, 8'h00, x, r);
    chk(r, 1'b0, "slave error");
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp,
    input string what);
    logic [31:0] x;
    rd(idx, x);
    chk(x, {24'h0, exp}, what);
  endtask

  task automatic vec_chk(input logic [4:0] n);
    chk({10'h0, cpu_vec}, {10'h0, 1'b1, n, 10'h0, n, 1'b0}, "vector");
  endtask

  task automatic novec();
    chk(cpu_vec.valid, 1'b0, "vector valid");
  endtask

  task automatic pulse(input logic [11:0] v);
    @(posedge clk);
    periph_evt <= pic_evt_type'(v);
    @(posedge clk);
    periph_evt <= '0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd_chk(ridx[i], rval[i], "reset value");
    end
    chk(cpu_imask, 1'b1, "mask bit");
    $display("test reset done");
    wr(PIC_IDX_PIN_EDGE, 8'h00);
    rd_chk(PIC_IDX_PIN_EDGE, 8'hE0, "edge reg");
    wr(PIC_IDX_PIN_EDGE, 8'h1F);
    rd_chk(PIC_IDX_PIN_EDGE, 8'hFF, "edge reg");
    wr(PIC_IDX_FLAG_ONE, 8'hFF);
    rd_chk(PIC_IDX_FLAG_ONE, 8'h20, "flag reg");
    apb(1'b0, 16'hFF00, 8'h00, d, e);
    chk(e, 1'b1, "unmapped");
    pstrb <= 4'h0;
    wr(PIC_IDX_EN_TWO, 8'hFF);
    pstrb <= 4'hF;
    rd_chk(PIC_IDX_EN_TWO, 8'h00, "strobe");
    wr(PIC_IDX_PIN_EDGE, 8'h10);
    conv_pin <= 1'b0;
    cyc(8);
    chk(conv_cnt, 0, "trigger");
    conv_pin <= 1'b1;
    cyc(8);
    chk(conv_cnt, 1, "trigger");
    wr(PIC_IDX_PIN_EDGE, 8'h00);
    conv_pin <= 1'b0;
    cyc(8);
    chk(conv_cnt, 2, "trigger");
    $display("test registers done");
    for (i = 0; i < 5; i++) begin
      wr(PIC_IDX_GMASK, 8'h01);
      wr(PIC_IDX_PIN_EDGE, 8'h01 << i);
      irq_pin[i] <= 1'b0;
      cyc(8);
      rd_chk(PIC_IDX_FLAG_ONE, 8'h20, "pin flag");
      irq_pin[i] <= 1'b1;
      cyc(8);
      rd_chk(PIC_IDX_FLAG_ONE, 8'h20 | (8'h01 << i), "pin flag");
      wr(PIC_IDX_GMASK, 8'h00);
      cyc(2);
      novec();
      wr(PIC_IDX_EN_ONE, 8'h01 << i);
      cyc(2);
      vec_chk(5'(4 + i));
      wr(PIC_IDX_GMASK, 8'h01);
      cyc(2);
      novec();
      wr(PIC_IDX_GMASK, 8'h00);
      wr(PIC_IDX_FLAG_ONE, 8'h00);
      cyc(2);
      novec();
      wr(PIC_IDX_PIN_EDGE, 8'h00);
      irq_pin[i] <= 1'b0;
      cyc(8);
      vec_chk(5'(4 + i));
      wr(PIC_IDX_FLAG_ONE, 8'h00);
      irq_pin[i] <= 1'b1;
      wr(PIC_IDX_EN_ONE, 8'h00);
    end
    wr(PIC_IDX_EN_ONE, 8'h20);
    for (i = 0; i < 8; i++) begin
      wr(PIC_IDX_WAKE_EDGE, (i % 2) ? (8'h01 << i) : 8'h00);
      wakeup_pin[i] <= 1'b0;
      cyc(8);
      rd_chk(PIC_IDX_WAKE_FLAG, (i % 2) ? 8'h00 : (8'h01 << i), "wake");
      wakeup_pin[i] <= 1'b1;
      cyc(8);
      wr(PIC_IDX_WAKE_FLAG, 8'hFF);
      rd_chk(PIC_IDX_WAKE_FLAG, 8'h01 << i, "wake");
      vec_chk(5'h09);
      wr(PIC_IDX_WAKE_FLAG, 8'h00);
    end
    $display("test pins done");
    wr(PIC_IDX_EN_ONE, 8'hC0);
    wr(PIC_IDX_EN_TWO, 8'hDF);
    for (i = 0; i < 12; i++) begin
      pulse(12'h001 << i);
      cyc(3);
      vec_chk(pvec[i]);
      wr(PIC_IDX_FLAG_ONE, 8'h00);
      wr(PIC_IDX_FLAG_TWO, 8'h00);
      cyc(2);
      novec();
    end
    ser_two <= 6'h3F;
    for (i = 0; i < 6; i++) begin
      ser_one <= 6'h01 << i;
      cyc(3);
      vec_chk(5'h11);
    end
    ser_one <= 6'h00;
    pulse(12'h403);
    cyc(3);
    vec_chk(5'h0B);
    wr(PIC_IDX_FLAG_ONE, 8'h00);
    cyc(2);
    vec_chk(5'h12);
    ser_two <= 6'h00;
    cyc(3);
    vec_chk(5'h13);
    wr(PIC_IDX_FLAG_TWO, 8'hBF);
    cyc(2);
    vec_chk(5'h14);
    rd(PIC_IDX_VECTOR, d);
    chk(d, {10'h0, 1'b1, 5'h14, 10'h0, 5'h14, 1'b0}, "vector reg");
    wr(PIC_IDX_FLAG_TWO, 8'h00);
    $display("test priority done");
    wr(PIC_IDX_IRQ_MASK, 8'h02);
    for (i = 0; i < 2; i++) begin
      wr(PIC_IDX_GMASK, 8'h00);
      wr(PIC_IDX_IRQ_STAT, 8'h07);
      ack_dly <= i ? 4'h0 : 4'h6;
      ack_en <= 1'b1;
      pulse(12'h100);
      cyc(12);
      chk(taken, 5'h0D, "taken");
      chk(cpu_imask, 1'b1, "mask bit");
      novec();
      chk(irq, 1'b1, "irq");
      rd(PIC_IDX_IRQ_STAT, d);
      chk(d & 32'h2, 32'h2, "status");
      wr(PIC_IDX_IRQ_STAT, 8'h02);
      cyc(2);
      chk(irq, 1'b0, "irq");
      ack_en <= 1'b0;
      wr(PIC_IDX_FLAG_TWO, 8'h00);
    end
    $display("test accept done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule // prioritized_interrupt_controller_tb
